// ===== hdl/pts_pkg.sv
// Constants for the PWM timebase selector.
// Assumes a 32-bit Avalon-MM slave with word addresses as byte offsets.
// What this block does
// - Four 2-bit selector fields in one register.
// - Code 00 selects Timer 2 timebase.
// - Code 01 selects Timer 4 timebase.
// - Code 10 selects Timer 6 timebase.
// - Field picks its unit's timebase; valid is set only in PWM mode.
package pts_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  OFS_TIMER_SELECT = 8'h00;
  localparam logic [7:0]  OFS_STATUS       = 8'h04;
  localparam logic [7:0]  RST_TIMER_SELECT = 8'h00;
  localparam int          SEL_W            = 2;
  localparam int          NUM_UNITS        = 4;
  localparam int          TMR_W            = 8;
  // ----------------------------------------
  // Selector codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PTS_TMR2 = 2'h0,
    PTS_TMR4 = 2'h1,
    PTS_TMR6 = 2'h2,
    PTS_RSVD = 2'h3
  } pts_sel_t;
endpackage

// ===== hdl/pts_timebase_selector.sv
// PWM timebase selector register and per-unit timer multiplexers.
// Assumes timer inputs and PWM-mode flags synchronous to clock.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module pts_timebase_selector
  import pts_pkg::*;
(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // Avalon-MM slave
  input  wire logic [7:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  output logic      [1:0]                 response,
  // Timer values
  input  wire logic [TMR_W-1:0]           tmr2Count,
  input  wire logic [TMR_W-1:0]           tmr4Count,
  input  wire logic [TMR_W-1:0]           tmr6Count,
  input  wire logic [TMR_W-1:0]           tmr2Period,
  input  wire logic [TMR_W-1:0]           tmr4Period,
  input  wire logic [TMR_W-1:0]           tmr6Period,
  // Units
  input  wire logic [NUM_UNITS-1:0]       unitPwmMode,
  output logic      [NUM_UNITS*TMR_W-1:0] unitTimebaseCount,
  output logic      [NUM_UNITS*TMR_W-1:0] unitTimebasePeriod,
  output logic      [NUM_UNITS-1:0]       unitTimebaseValid,
  output logic      [NUM_UNITS*SEL_W-1:0] unitTimebaseSel
);
  // ----------------------------------------
  // Register and bus
  // ----------------------------------------
  logic [7:0] selReg_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;

  // One wait cycle per access; answer comes on the second edge
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rdata_q;
  assign response    = resp_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      selReg_q <= RST_TIMER_SELECT;
    end else if (write && !ack_q && address == OFS_TIMER_SELECT && byteenable[0]) begin
      selReg_q <= writedata[7:0];
    end
  end

  // Unmapped addresses read zero, answer SLVERR
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else if ((read | write) && !ack_q) begin
      resp_q  <= (address == OFS_TIMER_SELECT || address == OFS_STATUS) ? 2'h0 : 2'h2;
      rdata_q <= 32'h0000_0000;
      if (read && address == OFS_TIMER_SELECT) begin
        rdata_q <= {24'h00_0000, selReg_q};
      end else if (read && address == OFS_STATUS) begin
        rdata_q <= {28'h000_0000, unitTimebaseValid};
      end
    end
  end

  // ----------------------------------------
  // Per-unit multiplexers
  // ----------------------------------------
  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      pts_sel_t sel;
      assign sel = pts_sel_t'(selReg_q[u*SEL_W +: SEL_W]);
      assign unitTimebaseSel[u*SEL_W +: SEL_W] = selReg_q[u*SEL_W +: SEL_W];
      always_ff @(posedge clock) begin
        if (!nrst) begin
          unitTimebaseCount[u*TMR_W +: TMR_W]  <= '0;
          unitTimebasePeriod[u*TMR_W +: TMR_W] <= '0;
          unitTimebaseValid[u]                 <= 1'b0;
        end else begin
          unitTimebaseValid[u] <= unitPwmMode[u] && (sel != PTS_RSVD);
          case (sel)
            PTS_TMR2: begin
              unitTimebaseCount[u*TMR_W +: TMR_W]  <= tmr2Count;
              unitTimebasePeriod[u*TMR_W +: TMR_W] <= tmr2Period;
            end
            PTS_TMR4: begin
              unitTimebaseCount[u*TMR_W +: TMR_W]  <= tmr4Count;
              unitTimebasePeriod[u*TMR_W +: TMR_W] <= tmr4Period;
            end
            PTS_TMR6: begin
              unitTimebaseCount[u*TMR_W +: TMR_W]  <= tmr6Count;
              unitTimebasePeriod[u*TMR_W +: TMR_W] <= tmr6Period;
            end
            default: begin
              unitTimebaseCount[u*TMR_W +: TMR_W]  <= '0;
              unitTimebasePeriod[u*TMR_W +: TMR_W] <= '0;
            end
          endcase
        end
      end
    end
  endgenerate
endmodule

// ===== verification/pts_asserts.sv
// Checker on the selector's ports.
// Assumes binding to the selector top.
`timescale 1ns/100ps
module pts_asserts (
  input wire logic        clock, nrst, write, waitrequest,
  input wire logic [7:0]  address, tmr2Count, tmr4Count, tmr6Count, unitTimebaseSel,
  input wire logic [31:0] writedata, unitTimebaseCount,
  input wire logic [3:0]  byteenable, unitPwmMode, unitTimebaseValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sel_write_a: assert property (write && waitrequest && address == 0 && byteenable[0]
    |=> unitTimebaseSel == $past(writedata[7:0])) else $error("lost write");
  tmr2_pick_a: assert property (unitPwmMode[0] && unitTimebaseSel[1:0] == 0
    |=> unitTimebaseCount[7:0] == $past(tmr2Count)) else $error("not timer 2");
  tmr4_pick_a: assert property (unitPwmMode[1] && unitTimebaseSel[3:2] == 1
    |=> unitTimebaseCount[15:8] == $past(tmr4Count)) else $error("not timer 4");
  tmr6_pick_a: assert property (unitPwmMode[3] && unitTimebaseSel[7:6] == 2
    |=> unitTimebaseCount[31:24] == $past(tmr6Count)) else $error("not timer 6");
  pwm_only_a: assert property (!unitPwmMode[2] |=> !unitTimebaseValid[2]) else $error("valid off PWM");
endmodule
bind pts_timebase_selector pts_asserts chk (.*);

// ===== verification/pts_timebase_selector_tb.sv
// Bench: Avalon accesses to the selector, mux checks.
// Assumes one clock and a held request per access.
`timescale 1ns/100ps
module pts_timebase_selector_tb;
  logic        clock = 0, nrst = 0, read = 0, write = 0, waitrequest;
  logic [7:0]  address = 0, t2 = 0, t4 = 0, t6 = 0, d;
  logic [31:0] writedata = 0, readdata, q, unitTimebasePeriod;
  logic [3:0]  byteenable = 4'hF, unitPwmMode = 4'hF, unitTimebaseValid;
  logic [1:0]  response;
  int          fails = 0, n_compared = 0;
  pts_timebase_selector dut (.clock, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .response, .tmr2Count(t2), .tmr4Count(t4), .tmr6Count(t6), .tmr2Period(8'h22),
    .tmr4Period(8'h44), .tmr6Period(8'h66), .unitPwmMode, .unitTimebaseCount(), .unitTimebasePeriod,
    .unitTimebaseValid, .unitTimebaseSel());
  initial forever #12.5 clock = ~clock;
  // Timers run apart so a wrong pick shows
  always @(posedge clock) begin
    t2 <= t2 + 1;
    t4 <= t4 + 3;
    t6 <= t6 + 5;
  end
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    @(posedge clock iff !waitrequest);
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  // Reserved code reads as period zero
  function automatic logic [7:0] ep(logic [1:0] c);
    return c == 3 ? 8'h00 : 8'h22 * (c + 1);
  endfunction
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1;
    acc(0, 8'h00, 0, q); chk(q, 0);
    for (int i = 0; i < 4; i++) begin
      d = (8'hE4 << 2 * i) | (8'hE4 >> (8 - 2 * i));
      unitPwmMode <= ~(4'h1 << i);
      acc(1, 8'h00, {24'h0, d}, q);
      acc(0, 8'h00, 0, q); chk(q, d);
      repeat (2) @(posedge clock);
      for (int u = 0; u < 4; u++) begin
        if (unitPwmMode[u]) chk(unitTimebasePeriod[8*u+:8], ep(d[2*u+:2]));
        chk(unitTimebaseValid[u], unitPwmMode[u] && d[2*u+:2] != 3);
      end
    end
    byteenable <= 0;
    acc(1, 8'h00, 32'h0000_00FF, q);
    byteenable <= 4'hF;
    acc(1, 8'h04, 32'h0000_00FF, q);
    acc(0, 8'h08, 0, q); chk(q, 0); chk(response, 2'h2);
    acc(0, 8'h00, 0, q); chk(q, d);
    chk(response, 2'h0);
    // Units 0 and 1 in PWM with legal codes
    acc(0, 8'h04, 0, q); chk(q, 32'h0000_0003);
    wrap_up;
  end
endmodule
